// ===== logic/host_port_pkg.sv
// constants and carrier types for the tape controller host port registers
package host_port_pkg;
    // unit status readback bit positions
    localparam int unsigned ST_HOST_WRITE_BIT = 0;
    localparam int unsigned ST_POLL_READ_BIT = 1;
    localparam int unsigned ST_ERASE_N_BIT = 2;
    localparam int unsigned ST_WGATE_N_BIT = 3;
    localparam int unsigned ST_IRQ_N_BIT = 4;
    localparam int unsigned ST_IRQ_DONE_N_BIT = 5;
    localparam int unsigned ST_PARITY_N_BIT = 6;
    localparam int unsigned ST_CABLE_BIT = 7;
    localparam int unsigned ST_UNIT_LSB = 8;
    // control latch bit addresses (local address bits 3..1)
    localparam logic [2:0] CTL_DRIVE_ERASE = 3'h0;
    localparam logic [2:0] CTL_WRITE_GATE = 3'h1;
    localparam logic [2:0] CTL_GAP_DETECT = 3'h2;
    localparam logic [2:0] CTL_CLEAR_WRITE_FLAG = 3'h3;
    localparam logic [2:0] CTL_CLEAR_POLL_FLAG = 3'h4;
    localparam logic [2:0] CTL_DIAG_MODE = 3'h5;
    localparam logic [2:0] CTL_LED1_OFF = 3'h6;
    localparam logic [2:0] CTL_LED2_OFF = 3'h7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] EXCHANGE_RESET = 16'h0000;
    // host bus strobes carried together
    typedef struct packed {
        logic match;
        logic addr1;
        logic sync;
        logic dout;
        logic din;
        logic vector_ack;
    } host_strobe_t;
    // local processor access carried together
    typedef struct packed {
        logic rd;
        logic wr;
        logic misc_chip_select;
        logic misc_register_enable;
        logic exchange_register_select;
        logic revision_select;
        logic [2:0] latch_addr;
    } local_access_t;
endpackage

// ===== logic/host_decode.sv
// host bus cycle decoder for the status exchange and poll locations
`timescale 1ns/100ps
module host_decode
(
    input wire host_port_pkg::host_strobe_t i_strobe, // host bus strobes
    output logic o_host_write_decode,                 // status exchange write
    output logic o_host_read_decode,                  // status exchange read
    output logic o_poll_read,                         // poll register read
    output logic o_poll_write                         // poll register write
);
    import host_port_pkg::*;

    logic sel_exchange;
    logic sel_poll;

    always_comb
    begin
        sel_exchange = i_strobe.match && i_strobe.addr1 && i_strobe.sync;
        sel_poll = i_strobe.match && !i_strobe.addr1 && i_strobe.sync;
        o_host_write_decode = sel_exchange && i_strobe.dout;
        o_host_read_decode = sel_exchange && i_strobe.din;
        o_poll_read = sel_poll && i_strobe.din;
        o_poll_write = sel_poll && i_strobe.dout;
    end
endmodule

// ===== logic/host_port_regs.sv
// tape controller host port register bank
`timescale 1ns/100ps
module host_port_regs
(
    input wire logic i_core_clk,                           // 50 MHz clock
    input wire logic i_reset_n,                            // power-up reset, sync
    input wire host_port_pkg::local_access_t i_local,      // local processor access
    input wire logic [15:0] i_local_data,                  // local data bus in
    input wire host_port_pkg::host_strobe_t i_host,        // host bus strobes
    input wire logic [15:0] i_host_data,                   // host data lines in
    input wire logic i_host_irq_req,                       // interrupt request from local side
    input wire logic i_irq_done,                           // vector taken by host
    input wire logic i_parity_error,                       // host memory parity error
    input wire logic i_cable_in,                           // drive cable connected
    input wire logic [7:0] i_unit_switches,                // unit number switches
    input wire logic [7:0] i_revision_switches,            // revision switches
    output logic [15:0] o_local_data,                      // local data bus out
    output logic o_local_data_oe,                          // local bus driven
    output logic [15:0] o_host_data,                       // host data lines out
    output logic o_host_data_oe,                           // host bus driven
    output logic o_host_read_gate,                         // exchange data enabled onto host reads
    output logic o_drive_erase,                            // drive erase output
    output logic o_drive_write_gate,                       // drive write gate output
    output logic o_gap_detect_enable,                      // gap detect enable
    output logic o_diag_mode,                              // diagnostic mode
    output logic o_led1_off,                               // led 1 off
    output logic o_led2_off,                               // led 2 off
    output logic o_controller_init                         // reinit request pulse
);
    import host_port_pkg::*;

    logic host_write_decode;
    logic host_read_decode;
    logic poll_read;
    logic poll_write;

    logic host_write_flag_r;
    logic host_write_flag_nxt;
    logic poll_read_flag_r;
    logic poll_read_flag_nxt;
    logic [15:0] local_to_host_r;
    logic [15:0] local_to_host_nxt;
    logic [15:0] host_to_local_r;
    logic [15:0] host_to_local_nxt;
    logic host_read_gate_r;
    logic host_read_gate_nxt;
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic init_r;
    logic init_nxt;
    logic [15:0] local_data_r;
    logic [15:0] local_data_nxt;
    logic local_oe_r;
    logic local_oe_nxt;
    logic [15:0] host_data_r;
    logic [15:0] host_data_nxt;
    logic host_oe_r;
    logic host_oe_nxt;
    logic [15:0] status_word;
    logic soft_reset;

    host_decode u_decode
    (
        .i_strobe(i_host),
        .o_host_write_decode(host_write_decode),
        .o_host_read_decode(host_read_decode),
        .o_poll_read(poll_read),
        .o_poll_write(poll_write)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // flags, control latch and status exchange latches

    assign soft_reset = init_r;

    always_comb
    begin
        host_write_flag_nxt = host_write_flag_r;
        poll_read_flag_nxt = poll_read_flag_r;
        ctl_nxt = ctl_r;
        local_to_host_nxt = local_to_host_r;
        host_to_local_nxt = host_to_local_r;
        host_read_gate_nxt = host_read_gate_r;
        init_nxt = poll_write;
        // addressable latch: local data bit 0 sets or clears the addressed bit
        if (i_local.wr && i_local.misc_chip_select)
        begin
            ctl_nxt[i_local.latch_addr] = i_local_data[0];
        end
        if (ctl_r[CTL_CLEAR_WRITE_FLAG])
        begin
            host_write_flag_nxt = 1'b0;
        end
        if (ctl_r[CTL_CLEAR_POLL_FLAG])
        begin
            poll_read_flag_nxt = 1'b0;
        end
        // setting wins over a clear in the same cycle
        if (host_write_decode)
        begin
            host_write_flag_nxt = 1'b1;
            host_to_local_nxt = i_host_data;
        end
        if (poll_read)
        begin
            poll_read_flag_nxt = 1'b1;
        end
        if (i_local.wr && i_local.exchange_register_select)
        begin
            local_to_host_nxt = i_local_data;
            host_read_gate_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n || soft_reset)
        begin
            host_write_flag_r <= 1'b0;
            poll_read_flag_r <= 1'b0;
            ctl_r <= CTL_RESET;
            local_to_host_r <= EXCHANGE_RESET;
            host_to_local_r <= EXCHANGE_RESET;
            host_read_gate_r <= 1'b0;
            init_r <= 1'b0;
        end
        else
        begin
            host_write_flag_r <= host_write_flag_nxt;
            poll_read_flag_r <= poll_read_flag_nxt;
            ctl_r <= ctl_nxt;
            local_to_host_r <= local_to_host_nxt;
            host_to_local_r <= host_to_local_nxt;
            host_read_gate_r <= host_read_gate_nxt;
            init_r <= init_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // local and host read paths

    always_comb
    begin
        status_word = 16'h0000;
        status_word[ST_HOST_WRITE_BIT] = host_write_flag_r;
        status_word[ST_POLL_READ_BIT] = poll_read_flag_r;
        status_word[ST_ERASE_N_BIT] = !ctl_r[CTL_DRIVE_ERASE];
        status_word[ST_WGATE_N_BIT] = !ctl_r[CTL_WRITE_GATE];
        status_word[ST_IRQ_N_BIT] = !i_host_irq_req;
        status_word[ST_IRQ_DONE_N_BIT] = !i_irq_done;
        status_word[ST_PARITY_N_BIT] = !i_parity_error;
        status_word[ST_CABLE_BIT] = i_cable_in;
        status_word[ST_UNIT_LSB +: 8] = i_unit_switches;

        local_data_nxt = 16'h0000;
        local_oe_nxt = 1'b0;
        if (i_local.rd && i_local.misc_chip_select && i_local.misc_register_enable)
        begin
            local_data_nxt = status_word;
            local_oe_nxt = 1'b1;
        end
        else if (i_local.rd && i_local.revision_select)
        begin
            local_data_nxt = {8'h00, i_revision_switches};
            local_oe_nxt = 1'b1;
        end
        else if (i_local.rd && i_local.exchange_register_select)
        begin
            local_data_nxt = host_to_local_r;
            local_oe_nxt = 1'b1;
        end

        host_data_nxt = 16'h0000;
        host_oe_nxt = 1'b0;
        if (i_host.vector_ack)
        begin
            host_data_nxt = local_to_host_r;
            host_oe_nxt = 1'b1;
        end
        else if (host_read_decode)
        begin
            host_oe_nxt = 1'b1;
            host_data_nxt = host_read_gate_r ? local_to_host_r : 16'h0000;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            local_data_r <= 16'h0000;
            local_oe_r <= 1'b0;
            host_data_r <= 16'h0000;
            host_oe_r <= 1'b0;
        end
        else
        begin
            local_data_r <= local_data_nxt;
            local_oe_r <= local_oe_nxt;
            host_data_r <= host_data_nxt;
            host_oe_r <= host_oe_nxt;
        end
    end

    assign o_local_data = local_data_r;
    assign o_local_data_oe = local_oe_r;
    assign o_host_data = host_data_r;
    assign o_host_data_oe = host_oe_r;
    assign o_host_read_gate = host_read_gate_r;
    assign o_drive_erase = ctl_r[CTL_DRIVE_ERASE];
    assign o_drive_write_gate = ctl_r[CTL_WRITE_GATE];
    assign o_gap_detect_enable = ctl_r[CTL_GAP_DETECT];
    assign o_diag_mode = ctl_r[CTL_DIAG_MODE];
    assign o_led1_off = ctl_r[CTL_LED1_OFF];
    assign o_led2_off = ctl_r[CTL_LED2_OFF];
    assign o_controller_init = init_r;
endmodule

// ===== sim/host_port_props.sv
// assertion checker for the host port register bank
`timescale 1ns/100ps
module host_port_props
(
    input wire logic i_core_clk, // clock
    input wire logic i_reset_n, // sync reset
    input wire host_port_pkg::local_access_t i_local, // local access
    input wire host_port_pkg::host_strobe_t i_host, // host strobes
    input wire logic [7:0] i_unit_switches, // unit switches
    input wire logic [7:0] i_revision_switches, // revision switches
    input wire logic i_cable_in, // cable
    input wire logic i_parity_error, // parity
    input wire logic i_irq_done, // irq done
    input wire logic i_host_irq_req, // irq request
    input wire logic [15:0] o_local_data, // local data
    input wire logic o_local_data_oe, // local enable
    input wire logic [15:0] o_host_data, // host data
    input wire logic o_host_data_oe, // host enable
    input wire logic o_host_read_gate, // read gate
    input wire logic o_drive_erase, // erase
    input wire logic o_drive_write_gate, // write gate
    input wire logic o_controller_init // reinit pulse
);
    import host_port_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    wire st_rd = i_local.rd & i_local.misc_chip_select & i_local.misc_register_enable;
    wire poll_wr = i_host.match & i_host.sync & !i_host.addr1 & i_host.dout;
    wire ex_rd = i_host.match & i_host.sync & i_host.addr1 & i_host.din & !i_host.vector_ack;
    sequence host_wr;
        i_host.match & i_host.sync & i_host.addr1 & i_host.dout;
    endsequence
    sequence stat_rd;
        st_rd;
    endsequence
    chk_status_unit: assert property (st_rd |=> o_local_data_oe
        && o_local_data[15:7] == $past({i_unit_switches, i_cable_in})) else $error("unit or cable bits wrong");
    chk_status_low: assert property (st_rd |=> o_local_data[6:2] == ~$past({i_parity_error,
        i_irq_done, i_host_irq_req, o_drive_write_gate, o_drive_erase})) else $error("active low bits wrong");
    chk_revision_read: assert property (i_local.rd & i_local.revision_select & !st_rd
        |=> o_local_data == {8'h00, $past(i_revision_switches)}) else $error("revision read wrong");
    chk_vector_out: assert property (i_host.vector_ack |=> o_host_data_oe) else $error("vector not driven");
    chk_write_flag: assert property (host_wr ##[1:3] stat_rd |=> o_local_data[0]) else $error("flag not set");
    chk_init_pulse: assert property ($rose(poll_wr) |=> o_controller_init) else $error("no reinit pulse");
    chk_gate_zero: assert property (ex_rd & !o_host_read_gate |=> o_host_data == 16'h0000)
        else $error("host read not zero");
    chk_init_clears: assert property (o_controller_init |-> ##2 !o_host_read_gate) else $error("gate kept");
    chk_read_enable: assert property (ex_rd |=> o_host_data_oe) else $error("host read not driven");
    chk_host_idle: assert property (!i_host.vector_ack & !ex_rd |=> !o_host_data_oe)
        else $error("host bus driven while idle");
    chk_local_enable: assert property (i_local.rd & (i_local.revision_select | i_local.exchange_register_select)
        |=> o_local_data_oe) else $error("local read not driven");
endmodule
bind host_port_regs host_port_props host_port_props_i (.i_core_clk, .i_reset_n, .i_local, .i_host,
    .i_unit_switches, .i_revision_switches, .i_cable_in, .i_parity_error, .i_irq_done, .i_host_irq_req,
    .o_local_data, .o_local_data_oe, .o_host_data, .o_host_data_oe, .o_host_read_gate, .o_drive_erase,
    .o_drive_write_gate, .o_controller_init);

// ===== sim/host_cpu_model.sv
// behavioural host processor on the host bus side
`timescale 1ns/100ps
module host_cpu_model
(
    input wire logic i_core_clk, // clock
    input wire logic [15:0] i_rdata, // data from port
    output host_port_pkg::host_strobe_t o_strobe, // strobes
    output logic [15:0] o_wdata // data lines
);
    import host_port_pkg::*;
    initial
    begin
        o_strobe = '0;
        o_wdata = 16'h0000;
    end
    // reads hold one more edge so the registered answer is taken
    task automatic cycle(input logic a1, input logic rd, input logic vec, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge i_core_clk);
        #1;
        o_strobe = '{match: !vec, addr1: a1, sync: !vec, dout: !rd & !vec, din: rd & !vec, vector_ack: vec};
        o_wdata = d;
        @(posedge i_core_clk);
        if (rd)
        begin
            @(posedge i_core_clk);
        end
        q = i_rdata;
        #1;
        o_strobe = '0;
        o_wdata = ~d;
    endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the host port register bank
`timescale 1ns/100ps
module tb;
    import host_port_pkg::*;
    logic i_core_clk = 1'h0;
    logic i_reset_n = 1'h0;
    local_access_t loc = '0;
    logic [15:0] ldata = 16'h0000;
    host_strobe_t hs;
    logic [15:0] hd, o_local_data, o_host_data, q, v;
    logic irq = 1'h0, done = 1'h0, par = 1'h0, cab = 1'h0;
    logic [7:0] unit = 8'h00, rev = 8'h00, latch = 8'h00;
    logic o_local_data_oe, o_host_data_oe, o_host_read_gate, o_controller_init;
    wire logic [5:0] ctl;
    logic hwf = 1'h0, prf = 1'h0;
    int n_fail = 0, total_checks = 0;
    host_port_regs host_port_regs_i (.i_core_clk, .i_reset_n, .i_local(loc), .i_local_data(ldata),
        .i_host(hs), .i_host_data(hd), .i_host_irq_req(irq), .i_irq_done(done), .i_parity_error(par),
        .i_cable_in(cab), .i_unit_switches(unit), .i_revision_switches(rev), .o_local_data, .o_local_data_oe,
        .o_host_data, .o_host_data_oe, .o_host_read_gate, .o_drive_erase(ctl[0]), .o_drive_write_gate(ctl[1]),
        .o_gap_detect_enable(ctl[2]), .o_diag_mode(ctl[3]), .o_led1_off(ctl[4]), .o_led2_off(ctl[5]),
        .o_controller_init);
    host_cpu_model host_cpu_model_i (.i_core_clk, .i_rdata(o_host_data), .o_strobe(hs), .o_wdata(hd));
    initial
    begin
        forever #10 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic lop(input logic [8:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        #1;
        loc = local_access_t'(a);
        ldata = d;
        repeat (2) @(posedge i_core_clk);
        q = o_local_data;
        #1;
        loc = '0;
        ldata = ~d;
    endtask
    function automatic logic [15:0] status();
        return {unit, cab, ~par, ~done, ~irq, ~latch[1], ~latch[0], prf, hwf};
    endfunction
    task automatic ctl_wr(input int a, input logic b);
        lop(9'h0C0 | 9'(a), {15'h0000, b});
        latch[a] = b;
        hwf = hwf & !(b && a == 3);
        prf = prf & !(b && a == 4);
        check("control outputs", {10'h000, ctl}, {10'h000, latch[7:5], latch[2:0]});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(71306));
        repeat (8) @(posedge i_core_clk);
        #1;
        i_reset_n = 1'h1;
        repeat (4)
        begin
            {unit, rev, irq, done, par, cab} = 20'($urandom);
            lop(9'h160, 16'h0000);
            check("status", q, status());
            lop(9'h108, 16'h0000);
            check("revision", q, {8'h00, rev});
        end
        host_cpu_model_i.cycle(1'h1, 1'h1, 1'h0, 16'h0000, q);
        check("read before load", q, 16'h0000);
        v = 16'($urandom);
        host_cpu_model_i.cycle(1'h1, 1'h0, 1'h0, v, q);
        hwf = 1'h1;
        lop(9'h160, 16'h0000);
        check("write flag", q, status());
        lop(9'h110, 16'h0000);
        check("host to local", q, v);
        host_cpu_model_i.cycle(1'h0, 1'h1, 1'h0, 16'h0000, q);
        prf = 1'h1;
        for (int a = 0; a < 8; a++)
        begin
            ctl_wr(a, 1'h1);
            lop(9'h160, 16'h0000);
            check("flags and readback", q, status());
            ctl_wr(a, 1'h0);
        end
        v = 16'($urandom);
        lop(9'h090, v);
        check("read gate", {15'h0000, o_host_read_gate}, 16'h0001);
        host_cpu_model_i.cycle(1'h1, 1'h1, 1'h0, 16'h0000, q);
        check("host read", q, v);
        host_cpu_model_i.cycle(1'h0, 1'h1, 1'h1, 16'h0000, q);
        check("vector", q, v);
        host_cpu_model_i.cycle(1'h1, 1'h0, 1'h0, ~v, q);
        host_cpu_model_i.cycle(1'h0, 1'h1, 1'h0, 16'h0000, q);
        host_cpu_model_i.cycle(1'h0, 1'h0, 1'h0, 16'h0000, q);
        {hwf, prf, latch} = 10'h000;
        repeat (2) @(posedge i_core_clk);
        #1;
        check("gate after reinit", {15'h0000, o_host_read_gate}, 16'h0000);
        lop(9'h160, 16'h0000);
        check("status after reinit", q, status());
        lop(9'h110, 16'h0000);
        check("latch after reinit", q, 16'h0000);
        host_cpu_model_i.cycle(1'h1, 1'h1, 1'h0, 16'h0000, q);
        check("host read after reinit", q, 16'h0000);
        summarize();
    end
    initial
    begin
        repeat (3000) @(posedge i_core_clk);
        n_fail++;
        summarize();
    end
endmodule
